// ### host_agent_model.sv
// Processor bus agent model that issues requests and accepts responses
`timescale 1ns/10ps
module host_agent_model (
   // Clock and stall control
   input wire logic i_clk,
   input wire logic i_stall,
   // Request phase
   input wire logic i_req_ready,
   output logic o_req_valid,
   output logic [4:0] o_first,
   output logic [4:0] o_second,
   output logic [7:0] o_be,
   output logic o_locked,
   // Response and reply acceptance
   input wire logic i_resp_valid,
   input wire logic i_reply_valid,
   output logic o_resp_ready,
   output logic o_reply_ready
);
   initial begin
      {o_req_valid, o_first, o_second, o_be, o_locked, o_resp_ready, o_reply_ready} = '0;
   end
   // Drive one request just after an edge and hold it until taken
   task automatic issue(input logic [4:0] f, s, input logic [7:0] be, input logic lk);
      o_req_valid = 1'h1;
      o_first = f;
      o_second = s;
      o_be = be;
      o_locked = lk;
      do @(negedge i_clk); while (!i_req_ready);
      @(posedge i_clk);
      #1;
   endtask
   // Released lines show the inverse of their last value
   task automatic idle();
      o_req_valid = 1'h0;
      {o_first, o_second, o_be, o_locked} = ~{o_first, o_second, o_be, o_locked};
   endtask
   // Accept responses and replies unless stalled
   always @(posedge i_clk) begin
      #1;
      o_resp_ready = i_resp_valid && !i_stall;
      o_reply_ready = i_reply_valid && !i_stall;
   end
endmodule

// ### host_bus_transaction_decoder.sv
// Host bus in-order queue, transaction decode, routing and response selection
`timescale 1ns/10ps

module host_bus_transaction_decoder (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Request phase
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic [4:0] i_request_type_first_field,
   input wire logic [4:0] i_request_type_second_field,
   input wire logic [7:0] i_byte_lane_enables,
   input wire logic i_locked,
   // Address decode results for the request
   input wire logic i_hit_dram,
   input wire logic i_hit_cfg,
   input wire logic i_hit_gfx,
   // Snoop result and target readiness
   input wire logic i_snoop_hitm,
   input wire logic i_hub_busy,
   input wire logic i_dram_locked_busy,
   input wire logic i_defer_enable,
   // Response phase
   input wire logic i_resp_ready,
   output logic o_resp_valid,
   output logic [2:0] o_response_code,
   output logic [2:0] o_resp_target,
   output logic o_resp_error,
   output logic [7:0] o_resp_byte_lane_enables,
   output logic [5:0] o_resp_byte_count,
   // Deferred reply
   input wire logic i_defer_done,
   input wire logic [1:0] i_defer_done_tag,
   input wire logic i_reply_ready,
   output logic o_reply_valid,
   output logic [4:0] o_reply_request_type,
   output logic [1:0] o_reply_tag
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the incoming request
   host_txn_pkg::kind_e dec_kind;
   host_txn_pkg::target_e dec_tgt;
   logic dec_bad;
   logic [1:0] dec_len;
   logic [7:0] dec_be;
   logic [5:0] dec_cnt;
   logic [2:0] dec_rs;
   logic [4:0] ra;
   logic [4:0] rb;

   assign ra = i_request_type_first_field;
   assign rb = i_request_type_second_field;

   always_comb begin
      dec_kind = host_txn_pkg::KIND_BAD;
      dec_len = rb[host_txn_pkg::LEN_HI:host_txn_pkg::LEN_LO];
      case (ra)
         host_txn_pkg::REQA_INTA_SPEC: begin
            if (rb == host_txn_pkg::REQB_INTA) begin
               dec_kind = host_txn_pkg::KIND_INTA;
            end else if (rb == host_txn_pkg::REQB_SPECIAL) begin
               dec_kind = host_txn_pkg::KIND_SPECIAL;
            end
         end
         host_txn_pkg::REQA_BTM: begin
            if (rb == host_txn_pkg::REQB_BTM) begin
               dec_kind = host_txn_pkg::KIND_BTM;
            end
         end
         host_txn_pkg::REQA_IO_RD: dec_kind = host_txn_pkg::KIND_IO_RD;
         host_txn_pkg::REQA_IO_WR: dec_kind = host_txn_pkg::KIND_IO_WR;
         host_txn_pkg::REQA_MEM_RDINV,
         host_txn_pkg::REQA_MEM_CODE_RD,
         host_txn_pkg::REQA_MEM_DATA_RD: dec_kind = host_txn_pkg::KIND_MEM_RD;
         host_txn_pkg::REQA_MEM_WB: dec_kind = host_txn_pkg::KIND_MEM_WB;
         host_txn_pkg::REQA_MEM_WR: dec_kind = host_txn_pkg::KIND_MEM_WR;
         default: dec_kind = host_txn_pkg::KIND_BAD;
      endcase
   end

   // Size and length checks
   always_comb begin
      dec_bad = (dec_kind == host_txn_pkg::KIND_BAD);
      if (dec_kind == host_txn_pkg::KIND_MEM_RD || dec_kind == host_txn_pkg::KIND_MEM_WB ||
          dec_kind == host_txn_pkg::KIND_MEM_WR) begin
         if (ra[host_txn_pkg::ASZ_HI:host_txn_pkg::ASZ_LO] != host_txn_pkg::ASZ_32BIT) begin
            dec_bad = 1'b1;
         end
      end
      if (dec_kind == host_txn_pkg::KIND_IO_RD || dec_kind == host_txn_pkg::KIND_IO_WR ||
          dec_kind == host_txn_pkg::KIND_MEM_RD || dec_kind == host_txn_pkg::KIND_MEM_WB ||
          dec_kind == host_txn_pkg::KIND_MEM_WR) begin
         if (rb[host_txn_pkg::DSZ_HI:host_txn_pkg::DSZ_LO] != host_txn_pkg::DSZ_64BIT) begin
            dec_bad = 1'b1;
         end
         if (dec_len == host_txn_pkg::LEN_RSVD) begin
            dec_bad = 1'b1;
         end
      end
   end

   // Byte lanes and byte count from the length code
   always_comb begin
      dec_be = i_byte_lane_enables;
      dec_cnt = 6'h00;
      case (dec_len)
         host_txn_pkg::LEN_UPTO8: begin
            for (int b = 0; b < 8; b++) begin
               dec_cnt = dec_cnt + {5'h00, i_byte_lane_enables[b]};
            end
         end
         host_txn_pkg::LEN_16: begin
            dec_be = host_txn_pkg::BE_ALL;
            dec_cnt = 6'h10;
         end
         host_txn_pkg::LEN_32: begin
            dec_be = host_txn_pkg::BE_ALL;
            dec_cnt = 6'h20;
         end
         default: begin
            dec_be = 8'h00;
            dec_cnt = 6'h00;
         end
      endcase
   end

   // Target routing
   always_comb begin
      dec_tgt = host_txn_pkg::TGT_NONE;
      case (dec_kind)
         host_txn_pkg::KIND_INTA: dec_tgt = host_txn_pkg::TGT_HUB;
         host_txn_pkg::KIND_SPECIAL: dec_tgt = host_txn_pkg::TGT_SPECIAL;
         host_txn_pkg::KIND_BTM: dec_tgt = host_txn_pkg::TGT_NONE;
         host_txn_pkg::KIND_IO_RD,
         host_txn_pkg::KIND_IO_WR: begin
            if (i_hit_cfg) begin
               dec_tgt = host_txn_pkg::TGT_CFG;
            end else if (i_hit_gfx) begin
               dec_tgt = host_txn_pkg::TGT_GFX;
            end else begin
               dec_tgt = host_txn_pkg::TGT_HUB;
            end
         end
         host_txn_pkg::KIND_MEM_WB: dec_tgt = host_txn_pkg::TGT_DRAM;
         host_txn_pkg::KIND_MEM_RD,
         host_txn_pkg::KIND_MEM_WR: begin
            if (i_hit_gfx) begin
               dec_tgt = host_txn_pkg::TGT_GFX;
            end else if (i_hit_dram) begin
               dec_tgt = host_txn_pkg::TGT_DRAM;
            end else begin
               dec_tgt = host_txn_pkg::TGT_HUB;
            end
         end
         default: dec_tgt = host_txn_pkg::TGT_NONE;
      endcase
      if (dec_bad) begin
         dec_tgt = host_txn_pkg::TGT_NONE;
      end
   end

   // Response selection
   logic is_rd;
   logic is_wr;
   logic can_retry;
   logic can_defer;
   always_comb begin
      is_rd = (dec_kind == host_txn_pkg::KIND_MEM_RD) || (dec_kind == host_txn_pkg::KIND_IO_RD) ||
              (dec_kind == host_txn_pkg::KIND_INTA);
      is_wr = (dec_kind == host_txn_pkg::KIND_MEM_WR) || (dec_kind == host_txn_pkg::KIND_MEM_WB) ||
              (dec_kind == host_txn_pkg::KIND_IO_WR);
      // Writebacks are never retried
      can_retry = ((dec_tgt == host_txn_pkg::TGT_HUB) && (is_rd || is_wr) && i_hub_busy) ||
                  ((dec_tgt == host_txn_pkg::TGT_DRAM) && is_rd && i_locked &&
                   i_dram_locked_busy);
      can_defer = i_defer_enable && (((dec_tgt == host_txn_pkg::TGT_HUB) &&
                  (is_rd || dec_kind == host_txn_pkg::KIND_IO_WR)) ||
                  ((dec_tgt == host_txn_pkg::TGT_GFX) &&
                  (is_rd || dec_kind == host_txn_pkg::KIND_IO_WR)));
      if (can_retry) begin
         dec_rs = host_txn_pkg::RS_RETRY;
      end else if (i_snoop_hitm && !dec_bad && (is_rd || is_wr)) begin
         dec_rs = host_txn_pkg::RS_IWB;
      end else if (can_defer) begin
         dec_rs = host_txn_pkg::RS_DEFER;
      end else if (is_rd && !dec_bad && dec_cnt != 6'h00) begin
         dec_rs = host_txn_pkg::RS_DATA;
      end else begin
         dec_rs = host_txn_pkg::RS_NODATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // In-order queue
   logic [2:0] q_rs_ff [host_txn_pkg::QUEUE_DEPTH];
   logic [2:0] q_tgt_ff [host_txn_pkg::QUEUE_DEPTH];
   logic q_bad_ff [host_txn_pkg::QUEUE_DEPTH];
   logic [7:0] q_be_ff [host_txn_pkg::QUEUE_DEPTH];
   logic [5:0] q_cnt_ff [host_txn_pkg::QUEUE_DEPTH];
   logic [host_txn_pkg::QPTR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [host_txn_pkg::QPTR_W-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [2:0] count_ff, nxt_count;
   logic push;
   logic pop;

   assign o_req_ready = (count_ff < 3'(host_txn_pkg::QUEUE_DEPTH));
   assign push = i_req_valid && o_req_ready;
   assign pop = o_resp_valid && i_resp_ready;

   always_comb begin
      nxt_wr_ptr = push ? wr_ptr_ff + 2'h1 : wr_ptr_ff;
      nxt_rd_ptr = pop ? rd_ptr_ff + 2'h1 : rd_ptr_ff;
      nxt_count = count_ff + {2'h0, push} - {2'h0, pop};
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr_ff <= 2'h0;
         rd_ptr_ff <= 2'h0;
         count_ff <= 3'h0;
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   generate
      for (genvar e = 0; e < host_txn_pkg::QUEUE_DEPTH; e++) begin : g_entry
         logic wen;
         logic [2:0] nxt_rs;
         logic [2:0] nxt_tgt;
         logic nxt_bad;
         logic [7:0] nxt_be;
         logic [5:0] nxt_cnt;
         assign wen = push && (wr_ptr_ff == 2'(e));
         always_comb begin
            nxt_rs = q_rs_ff[e];
            nxt_tgt = q_tgt_ff[e];
            nxt_bad = q_bad_ff[e];
            nxt_be = q_be_ff[e];
            nxt_cnt = q_cnt_ff[e];
            if (wen) begin
               nxt_rs = dec_rs;
               nxt_tgt = dec_tgt;
               nxt_bad = dec_bad;
               nxt_be = (dec_kind == host_txn_pkg::KIND_BTM) ? 8'h00 : dec_be;
               nxt_cnt = (dec_kind == host_txn_pkg::KIND_BTM) ? 6'h00 : dec_cnt;
            end
         end
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               q_rs_ff[e] <= host_txn_pkg::RS_IDLE;
               q_tgt_ff[e] <= 3'h0;
               q_bad_ff[e] <= 1'b0;
               q_be_ff[e] <= 8'h00;
               q_cnt_ff[e] <= 6'h00;
            end else begin
               q_rs_ff[e] <= nxt_rs;
               q_tgt_ff[e] <= nxt_tgt;
               q_bad_ff[e] <= nxt_bad;
               q_be_ff[e] <= nxt_be;
               q_cnt_ff[e] <= nxt_cnt;
            end
         end
      end
   endgenerate

   // Response outputs from the queue head; idle code when empty
   assign o_resp_valid = (count_ff != 3'h0);
   assign o_response_code = o_resp_valid ? q_rs_ff[rd_ptr_ff] : host_txn_pkg::RS_IDLE;
   assign o_resp_target = q_tgt_ff[rd_ptr_ff];
   assign o_resp_error = o_resp_valid && q_bad_ff[rd_ptr_ff];
   assign o_resp_byte_lane_enables = q_be_ff[rd_ptr_ff];
   assign o_resp_byte_count = q_cnt_ff[rd_ptr_ff];

   ////////////////////////////////////////////////////////////////////////////
   // Deferred reply issue
   logic [host_txn_pkg::QUEUE_DEPTH-1:0] pend_ff, nxt_pend;
   logic [1:0] pend_tag;
   logic pend_any;
   logic reply_valid_ff, nxt_reply_valid;
   logic [1:0] reply_tag_ff, nxt_reply_tag;

   always_comb begin
      pend_any = 1'b0;
      pend_tag = 2'h0;
      for (int t = host_txn_pkg::QUEUE_DEPTH - 1; t >= 0; t--) begin
         if (pend_ff[t]) begin
            pend_any = 1'b1;
            pend_tag = 2'(t);
         end
      end
      nxt_pend = pend_ff;
      nxt_reply_valid = reply_valid_ff;
      nxt_reply_tag = reply_tag_ff;
      if (reply_valid_ff && i_reply_ready) begin
         nxt_reply_valid = 1'b0;
      end else if (!reply_valid_ff && pend_any) begin
         nxt_reply_valid = 1'b1;
         nxt_reply_tag = pend_tag;
         nxt_pend[pend_tag] = 1'b0;
      end
      if (i_defer_done) begin
         nxt_pend[i_defer_done_tag] = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pend_ff <= '0;
         reply_valid_ff <= 1'b0;
         reply_tag_ff <= 2'h0;
      end else begin
         pend_ff <= nxt_pend;
         reply_valid_ff <= nxt_reply_valid;
         reply_tag_ff <= nxt_reply_tag;
      end
   end

   assign o_reply_valid = reply_valid_ff;
   assign o_reply_request_type = host_txn_pkg::REQA_DEFER_REPLY;
   assign o_reply_tag = reply_tag_ff;

endmodule

// ### host_bus_transaction_decoder_tb.sv
// Self-checking testbench for the host bus transaction decoder
`timescale 1ns/10ps
module host_bus_transaction_decoder_tb;
   typedef struct packed {logic [4:0] f; logic [4:0] s; logic [7:0] be, c; logic [6:0] x;} row_s;
   // c: locked, dram, cfg, gfx, snoop hit, hub busy, locked busy, defer; x: code, target, error
   localparam row_s R [19] = '{
      '{5'h06, 5'h00, 8'hFF, 8'h40, 7'h72}, '{5'h04, 5'h01, 8'hFF, 8'h00, 7'h74},
      '{5'h02, 5'h02, 8'hFF, 8'h10, 7'h78}, '{5'h07, 5'h00, 8'h0F, 8'h40, 7'h52},
      '{5'h07, 5'h00, 8'h0F, 8'h04, 7'h14}, '{5'h05, 5'h02, 8'hFF, 8'h04, 7'h52},
      '{5'h10, 5'h00, 8'h01, 8'h00, 7'h74}, '{5'h11, 5'h00, 8'h01, 8'h21, 7'h56},
      '{5'h11, 5'h00, 8'h01, 8'h11, 7'h28}, '{5'h07, 5'h00, 8'hFF, 8'h11, 7'h58},
      '{5'h08, 5'h00, 8'h00, 8'h01, 7'h24}, '{5'h08, 5'h01, 8'h00, 8'h00, 7'h5A},
      '{5'h09, 5'h00, 8'hFF, 8'h00, 7'h50}, '{5'h06, 5'h00, 8'hFF, 8'h48, 7'h62},
      '{5'h06, 5'h00, 8'hFF, 8'hC2, 7'h12}, '{5'h06, 5'h00, 8'h00, 8'h40, 7'h52},
      '{5'h06, 5'h03, 8'hFF, 8'h40, 7'h51}, '{5'h0E, 5'h00, 8'hFF, 8'h40, 7'h51},
      '{5'h06, 5'h08, 8'hFF, 8'h40, 7'h51}};
   localparam int OIX [4] = '{2, 1, 0, 3};
   localparam logic [5:0] OBC [3] = '{6'h20, 6'h10, 6'h08};
   logic i_clk = 1'h0;
   logic i_srst, stall, i_defer_done;
   logic [1:0] i_defer_done_tag;
   logic [7:0] c;
   wire logic i_req_valid, i_locked, i_resp_ready, i_reply_ready;
   wire logic [4:0] i_request_type_first_field, i_request_type_second_field;
   wire logic [7:0] i_byte_lane_enables;
   logic o_req_ready, o_resp_valid, o_resp_error, o_reply_valid;
   logic [2:0] o_response_code, o_resp_target;
   logic [5:0] o_resp_byte_count, ec;
   logic [7:0] o_resp_byte_lane_enables, eb;
   logic [4:0] o_reply_request_type;
   logic [1:0] o_reply_tag;
   logic [20:0] r;
   logic [20:0] rq[$];
   logic [6:0] rp[$];
   int n_mismatch = 0;
   int compares = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #12.5 i_clk = ~i_clk;
   host_bus_transaction_decoder host_bus_transaction_decoder_i (
      .i_clk, .i_srst, .i_req_valid, .o_req_ready, .i_request_type_first_field,
      .i_request_type_second_field, .i_byte_lane_enables, .i_locked, .i_hit_dram(c[6]),
      .i_hit_cfg(c[5]), .i_hit_gfx(c[4]), .i_snoop_hitm(c[3]), .i_hub_busy(c[2]),
      .i_dram_locked_busy(c[1]), .i_defer_enable(c[0]), .i_resp_ready, .o_resp_valid,
      .o_response_code, .o_resp_target, .o_resp_error, .o_resp_byte_lane_enables,
      .o_resp_byte_count, .i_defer_done, .i_defer_done_tag, .i_reply_ready, .o_reply_valid,
      .o_reply_request_type, .o_reply_tag);
   host_agent_model host_agent_model_i (
      .i_clk, .i_stall(stall), .i_req_ready(o_req_ready), .o_req_valid(i_req_valid),
      .o_first(i_request_type_first_field), .o_second(i_request_type_second_field),
      .o_be(i_byte_lane_enables), .o_locked(i_locked), .i_resp_valid(o_resp_valid),
      .i_reply_valid(o_reply_valid), .o_resp_ready(i_resp_ready), .o_reply_ready(i_reply_ready));
   always @(posedge i_clk) begin
      if (!i_srst && o_resp_valid && i_resp_ready) begin
         rq.push_back({o_response_code, o_resp_target, o_resp_error, o_resp_byte_lane_enables,
                       o_resp_byte_count});
      end
      if (!i_srst && o_reply_valid && i_reply_ready) begin
         rp.push_back({o_reply_request_type, o_reply_tag});
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic send(input int k);
      c = R[k].c;
      host_agent_model_i.issue(R[k].f, R[k].s, R[k].be, R[k].c[7]);
   endtask
   task automatic wait_q(input int n);
      for (int i = 0; i < 40 && rq.size() + rp.size() < n; i++) begin
         @(posedge i_clk);
         #1;
      end
      if (rq.size() + rp.size() < n) begin
         n_mismatch++;
      end
   endtask
   task automatic end_sim();
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {i_srst, stall, i_defer_done, i_defer_done_tag, c} = {3'h4, 10'h000};
      repeat (2) @(posedge i_clk);
      #1;
      i_srst = 1'h0;
      cmp({o_req_ready, o_resp_valid, o_reply_valid, 2'h0, o_response_code}, 8'h80);
      for (int k = 0; k < 19; k++) begin
         send(k);
         host_agent_model_i.idle();
         wait_q(1);
         r = rq.pop_front();
         cmp({5'h0, r[20:18]}, {5'h0, R[k].x[6:4]});
         cmp({5'h0, r[17:15]}, {5'h0, R[k].x[3:1]});
         cmp({7'h0, r[14]}, {7'h0, R[k].x[0]});
         case (R[k].s[1:0])
            2'h0: {eb, ec} = {R[k].be, 6'($countones(R[k].be))};
            2'h1: {eb, ec} = {8'hFF, 6'h10};
            default: {eb, ec} = {8'hFF, 6'h20};
         endcase
         if (R[k].f == 5'h09) begin
            {eb, ec} = 14'h0000;
         end
         if (R[k].f == 5'h09 || (R[k].f[4:3] != 2'h1 && R[k].s[4:3] == 2'h0 &&
             R[k].s[1:0] != 2'h3)) begin
            cmp(r[13:6], eb);
            cmp({2'h0, r[5:0]}, {2'h0, ec});
         end
      end
      stall = 1'h1;
      foreach (OIX[k]) begin
         send(OIX[k]);
      end
      cmp({7'h0, o_req_ready}, 8'h00);
      host_agent_model_i.idle();
      stall = 1'h0;
      wait_q(4);
      foreach (OIX[k]) begin
         r = rq.pop_front();
         cmp({5'h0, r[20:18]}, {5'h0, R[OIX[k]].x[6:4]});
         if (k < 3) begin
            cmp({2'h0, r[5:0]}, {2'h0, OBC[k]});
         end
      end
      stall = 1'h1;
      send(0);
      send(3);
      host_agent_model_i.idle();
      i_srst = 1'h1;
      @(posedge i_clk);
      #1;
      i_srst = 1'h0;
      cmp({o_req_ready, o_resp_valid, o_reply_valid, 2'h0, o_response_code}, 8'h80);
      i_defer_done = 1'h1;
      i_defer_done_tag = 2'h2;
      @(posedge i_clk);
      #1;
      i_defer_done_tag = 2'h1;
      @(posedge i_clk);
      #1;
      i_defer_done = 1'h0;
      cmp({o_reply_valid, 5'h0, o_reply_tag}, 8'h82);
      stall = 1'h0;
      wait_q(2);
      cmp({1'h0, rp.pop_front()}, 8'h02);
      cmp({1'h0, rp.pop_front()}, 8'h01);
      end_sim();
   end
endmodule

// ### host_txn_checker.sv
// Assertion checker for the host bus transaction decoder
`timescale 1ns/10ps
module host_txn_checker (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Request phase
   input wire logic i_req_valid,
   input wire logic o_req_ready,
   input wire logic [4:0] i_request_type_first_field,
   input wire logic [4:0] i_request_type_second_field,
   // Response phase
   input wire logic i_resp_ready,
   input wire logic o_resp_valid,
   input wire logic [2:0] o_response_code,
   input wire logic o_resp_error,
   // Deferred reply
   input wire logic i_defer_done,
   input wire logic [1:0] i_defer_done_tag,
   input wire logic i_reply_ready,
   input wire logic o_reply_valid,
   input wire logic [4:0] o_reply_request_type,
   input wire logic [1:0] o_reply_tag
);
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic acc_empty;
   ////////////////////////////////////////////////////////////////////////////
   // Queue occupancy seen at the ports
   always_comb begin
      nxt_cnt = cnt_ff + 3'(i_req_valid && o_req_ready) - 3'(o_resp_valid && i_resp_ready);
      if (i_srst) begin
         nxt_cnt = 3'h0;
      end
   end
   always_ff @(posedge i_clk) begin
      cnt_ff <= nxt_cnt;
   end
   assign acc_empty = i_req_valid && o_req_ready && !o_resp_valid;
   ////////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   chk_ready_count: assert property (o_req_ready == (cnt_ff < 3'h4))
      else $error("request ready disagrees with queue occupancy");
   chk_idle_code: assert property (!o_resp_valid |-> o_response_code == 3'h0)
      else $error("response code not idle while queue empty");
   chk_no_bad_code: assert property (!(o_response_code inside {3'h3, 3'h4}))
      else $error("hard failure or reserved response code driven");
   chk_resp_stands: assert property (o_resp_valid && !i_resp_ready |=>
      o_resp_valid && $stable(o_response_code))
      else $error("head response changed before acceptance");
   chk_first_answer: assert property (acc_empty |=> o_resp_valid)
      else $error("no response after request into empty queue");
   chk_wb_no_retry: assert property (acc_empty && i_request_type_first_field == 5'h05
      |=> o_response_code != 3'h1)
      else $error("writeback answered with retry");
   chk_bad_len: assert property (acc_empty && i_request_type_second_field[1:0] == 2'h3
      |=> o_resp_error && o_response_code == 3'h5)
      else $error("reserved length not flagged");
   chk_reply_type: assert property (o_reply_valid |-> o_reply_request_type == 5'h00)
      else $error("deferred reply with wrong request code");
   chk_reply_follows: assert property (i_defer_done && !$past(i_defer_done) &&
      !o_reply_valid && !$past(o_reply_valid) |->
      ##2 o_reply_valid && o_reply_tag == $past(i_defer_done_tag, 2))
      else $error("deferred reply missing or wrong tag");
   chk_reply_stands: assert property (o_reply_valid && !i_reply_ready |=>
      o_reply_valid && $stable(o_reply_tag))
      else $error("deferred reply dropped before acceptance");
   cover property (!o_req_ready);
   cover property (o_resp_valid && o_response_code == 3'h1);
   cover property (o_reply_valid && i_reply_ready);
endmodule

bind host_bus_transaction_decoder host_txn_checker host_txn_checker_i (
   .i_clk, .i_srst, .i_req_valid, .o_req_ready, .i_request_type_first_field,
   .i_request_type_second_field, .i_resp_ready, .o_resp_valid, .o_response_code,
   .o_resp_error, .i_defer_done, .i_defer_done_tag, .i_reply_ready, .o_reply_valid,
   .o_reply_request_type, .o_reply_tag
);

// ### host_txn_pkg.sv
// Constants for the host bus transaction decoder
package host_txn_pkg;
   // Queue
   localparam int QUEUE_DEPTH = 4;
   localparam int QPTR_W = 2;
   // First request field codes
   localparam logic [4:0] REQA_DEFER_REPLY = 5'h00;
   localparam logic [4:0] REQA_INTA_SPEC = 5'h08;
   localparam logic [4:0] REQA_BTM = 5'h09;
   localparam logic [4:0] REQA_IO_RD = 5'h10;
   localparam logic [4:0] REQA_IO_WR = 5'h11;
   localparam logic [4:0] REQA_MEM_RDINV = 5'h02;
   localparam logic [4:0] REQA_MEM_CODE_RD = 5'h04;
   localparam logic [4:0] REQA_MEM_DATA_RD = 5'h06;
   localparam logic [4:0] REQA_MEM_WB = 5'h05;
   localparam logic [4:0] REQA_MEM_WR = 5'h07;
   // Second request field codes
   localparam logic [4:0] REQB_INTA = 5'h00;
   localparam logic [4:0] REQB_SPECIAL = 5'h01;
   localparam logic [4:0] REQB_BTM = 5'h00;
   // Size and length field positions and values
   localparam int ASZ_HI = 4;
   localparam int ASZ_LO = 3;
   localparam int DSZ_HI = 4;
   localparam int DSZ_LO = 3;
   localparam int LEN_HI = 1;
   localparam int LEN_LO = 0;
   localparam logic [1:0] ASZ_32BIT = 2'h0;
   localparam logic [1:0] DSZ_64BIT = 2'h0;
   localparam logic [1:0] LEN_UPTO8 = 2'h0;
   localparam logic [1:0] LEN_16 = 2'h1;
   localparam logic [1:0] LEN_32 = 2'h2;
   localparam logic [1:0] LEN_RSVD = 2'h3;
   localparam logic [7:0] BE_ALL = 8'hFF;
   // Response codes
   localparam logic [2:0] RS_IDLE = 3'h0;
   localparam logic [2:0] RS_RETRY = 3'h1;
   localparam logic [2:0] RS_DEFER = 3'h2;
   localparam logic [2:0] RS_NODATA = 3'h5;
   localparam logic [2:0] RS_IWB = 3'h6;
   localparam logic [2:0] RS_DATA = 3'h7;
   // Targets
   typedef enum logic [2:0] {
      TGT_NONE, TGT_DRAM, TGT_HUB, TGT_CFG, TGT_GFX, TGT_SPECIAL
   } target_e;
   // Transaction kinds
   typedef enum logic [3:0] {
      KIND_BAD, KIND_INTA, KIND_SPECIAL, KIND_BTM, KIND_IO_RD, KIND_IO_WR,
      KIND_MEM_RD, KIND_MEM_WB, KIND_MEM_WR
   } kind_e;
endpackage
